// ==== hdl/perm_rate_counter.v ====
// One port's error-rate counter, peak, leak timer, thresholds and reports
`timescale 1ns/1ps
`default_nettype none
`include "perm_regs.vh"

module perm_rate_counter (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // Events
  input wire err_event,
  input wire ms_tick,
  // Register writes
  input wire wr_rate,
  input wire wr_thresh,
  input wire [31:0] wdata,
  // Register contents
  output wire [31:0] rate_word,
  output wire [31:0] thresh_word,
  // Reports
  output reg failed_report,
  output reg degraded_report
);

  // ==================================================================
  // Stored fields
  reg [7:0] count;
  reg [7:0] peak;
  reg [1:0] over_limit_cap;
  reg [7:0] bias;
  reg [7:0] failed_limit;
  reg [7:0] degraded_limit;
  reg [23:0] ms_count;

  assign rate_word = {bias, 6'h00, over_limit_cap, peak, count};
  assign thresh_word = {failed_limit, degraded_limit, 16'h0000};

  // ==================================================================
  // Leak period decode; reserved codes leak never
  reg [23:0] period_ms;
  always @* begin
    case (bias)
      `PERM_BIAS_1MS: period_ms = `PERM_MS_1MS;
      `PERM_BIAS_10MS: period_ms = `PERM_MS_10MS;
      `PERM_BIAS_100MS: period_ms = `PERM_MS_100MS;
      `PERM_BIAS_1S: period_ms = `PERM_MS_1S;
      `PERM_BIAS_10S: period_ms = `PERM_MS_10S;
      `PERM_BIAS_100S: period_ms = `PERM_MS_100S;
      `PERM_BIAS_1000S: period_ms = `PERM_MS_1000S;
      `PERM_BIAS_10000S: period_ms = `PERM_MS_10000S;
      default: period_ms = 24'h000000;
    endcase
  end

  wire period_end = ms_tick && (period_ms != 24'h000000) && (ms_count + 24'h000001 >= period_ms);
  wire leak = period_end && (count != 8'h00);

  // ==================================================================
  // Growth ceiling above the failed threshold
  reg [8:0] ceiling;
  always @* begin
    case (over_limit_cap)
      `PERM_CAP_2: ceiling = {1'b0, failed_limit} + `PERM_GROW_2;
      `PERM_CAP_4: ceiling = {1'b0, failed_limit} + `PERM_GROW_4;
      `PERM_CAP_16: ceiling = {1'b0, failed_limit} + `PERM_GROW_16;
      default: ceiling = 9'h0ff;
    endcase
    if (failed_limit == 8'h00)
      ceiling = 9'h0ff;
  end

  wire grow = err_event && ({1'b0, count} < ceiling) && (count != 8'hff);

  reg [7:0] next_count;
  always @* begin
    next_count = count;
    if (grow && !leak)
      next_count = count + 8'h01;
    else if (leak && !grow)
      next_count = count - 8'h01;
  end

  // ==================================================================
  // Registers; a software write wins over a same-cycle event
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= `PERM_COUNT_RST;
      peak <= `PERM_PEAK_RST;
      over_limit_cap <= `PERM_CAP_RST;
      bias <= `PERM_BIAS_RST;
      failed_limit <= `PERM_FAILED_RST;
      degraded_limit <= `PERM_DEGRADED_RST;
      ms_count <= 24'h000000;
      failed_report <= 1'b0;
      degraded_report <= 1'b0;
    end else begin
      failed_report <= 1'b0;
      degraded_report <= 1'b0;
      if (wr_rate) begin
        count <= wdata[`PERM_COUNT_LSB +: 8];
        peak <= wdata[`PERM_PEAK_LSB +: 8];
        over_limit_cap <= wdata[`PERM_CAP_LSB +: 2];
        bias <= wdata[`PERM_BIAS_LSB +: 8];
        ms_count <= 24'h000000;
      end else begin
        count <= next_count;
        if (next_count > peak)
          peak <= next_count;
        if (period_end || period_ms == 24'h000000)
          ms_count <= 24'h000000;
        else if (ms_tick)
          ms_count <= ms_count + 24'h000001;
        if (next_count != count && next_count == failed_limit && failed_limit != 8'h00)
          failed_report <= 1'b1;
        if (next_count != count && next_count == degraded_limit && degraded_limit != 8'h00)
          degraded_report <= 1'b1;
      end
      if (wr_thresh) begin
        failed_limit <= wdata[`PERM_FAILED_LSB +: 8];
        degraded_limit <= wdata[`PERM_DEGRADED_LSB +: 8];
      end
    end
  end

endmodule // perm_rate_counter

`default_nettype wire

// ==== hdl/perm_regs.vh ====
// Register offsets, field positions, reset values and timing counts of the error-rate monitor
`ifndef PERM_REGS_VH
`define PERM_REGS_VH

// ==================================================================
// Register map, one window of 0x20 bytes per port
`define PERM_PORT_STRIDE 8'h20
`define PERM_RATE_OFS 5'h00
`define PERM_THRESH_OFS 5'h04
`define PERM_CAPT_FLAG_OFS 5'h08
`define PERM_HDR_WORD3_OFS 5'h0c
`define PERM_MAP_TOP_BIT 7

// ==================================================================
// Error-rate register fields
`define PERM_COUNT_LSB 0
`define PERM_PEAK_LSB 8
`define PERM_CAP_LSB 16
`define PERM_BIAS_LSB 24
`define PERM_COUNT_RST 8'h00
`define PERM_PEAK_RST 8'h00
`define PERM_CAP_RST 2'h0
`define PERM_BIAS_RST 8'hff

// ==================================================================
// Threshold register fields
`define PERM_DEGRADED_LSB 16
`define PERM_FAILED_LSB 24
`define PERM_DEGRADED_RST 8'hff
`define PERM_FAILED_RST 8'hff

// ==================================================================
// Capture flag register fields
`define PERM_CAPT_VALID_BIT 0

// ==================================================================
// Over-limit cap codes and their allowed growth
`define PERM_CAP_2 2'h0
`define PERM_CAP_4 2'h1
`define PERM_CAP_16 2'h2
`define PERM_CAP_NONE 2'h3
`define PERM_GROW_2 9'h002
`define PERM_GROW_4 9'h004
`define PERM_GROW_16 9'h010

// ==================================================================
// Leak bias codes and their periods in milliseconds
`define PERM_BIAS_OFF 8'h00
`define PERM_BIAS_1MS 8'h01
`define PERM_BIAS_10MS 8'h03
`define PERM_BIAS_100MS 8'h07
`define PERM_BIAS_1S 8'h0f
`define PERM_BIAS_10S 8'h1f
`define PERM_BIAS_100S 8'h3f
`define PERM_BIAS_1000S 8'h7f
`define PERM_BIAS_10000S 8'hff
`define PERM_MS_1MS 24'h000001
`define PERM_MS_10MS 24'h00000a
`define PERM_MS_100MS 24'h000064
`define PERM_MS_1S 24'h0003e8
`define PERM_MS_10S 24'h002710
`define PERM_MS_100S 24'h0186a0
`define PERM_MS_1000S 24'h0f4240
`define PERM_MS_10000S 24'h989680

// ==================================================================
// Timing: leak base tick
`define PERM_CLK_PERIOD_NS 10
`define PERM_LEAK_BASE_NS 1000000
`define PERM_LEAK_BASE_CYCLES (`PERM_LEAK_BASE_NS / `PERM_CLK_PERIOD_NS)

`endif

// ==== hdl/perm_top.v ====
// Four-port error-rate monitor with first-header capture (held until cleared) behind an AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
`include "perm_regs.vh"

module perm_top #(
  parameter NUM_PORTS = 4,
  parameter LEAK_BASE_CYCLES = `PERM_LEAK_BASE_CYCLES
) (
  // Clock and reset
  input wire sys_clk,
  input wire rst_n,
  // AHB-Lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg [31:0] hrdata,
  output reg hresp,
  // Error detect logic, one bit per port (32 header bits per port), same clock
  input wire [NUM_PORTS-1:0] tx_error,
  input wire [NUM_PORTS-1:0] capture_strobe,
  input wire [32*NUM_PORTS-1:0] capture_header_in,
  // Error reports, one-cycle pulses per port
  output wire [NUM_PORTS-1:0] failed_report,
  output wire [NUM_PORTS-1:0] degraded_report,
  // Capture state per port
  output reg [NUM_PORTS-1:0] capture_valid_flag
);

  // ==================================================================
  // Leak base tick, shared by all ports
  // One prescaler keeps the ports' leak periods on a common time base
  // and saves three wide counters; the cost is up to 1 ms of phase error.
  localparam [31:0] TICK_LAST = LEAK_BASE_CYCLES - 1;
  reg [31:0] tick_count;
  reg ms_tick;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_count <= 32'h00000000;
      ms_tick <= 1'b0;
    end else begin
      if (tick_count >= TICK_LAST) begin
        tick_count <= 32'h00000000;
        ms_tick <= 1'b1;
      end else begin
        tick_count <= tick_count + 32'h00000001;
        ms_tick <= 1'b0;
      end
    end
  end

  // ==================================================================
  // AHB-Lite address phase
  // Every NONSEQ transfer takes one wait state so read data comes from a flop; SEQ transfers are not taken.
  localparam [1:0] HTRANS_NONSEQ = 2'h2;
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_DATA = 2'b10;

  reg [1:0] bus_state;
  reg [31:0] addr_q;
  reg write_q;

  wire take = hsel && hready && (htrans == HTRANS_NONSEQ);

  // ==================================================================
  // Address decode of the pending transfer
  wire in_map = (addr_q[31:`PERM_MAP_TOP_BIT] == 25'h0000000);
  wire [1:0] port_sel = addr_q[6:5];
  wire [4:0] reg_ofs = addr_q[4:0];
  wire hit_rate = in_map && (reg_ofs == `PERM_RATE_OFS);
  wire hit_thresh = in_map && (reg_ofs == `PERM_THRESH_OFS);
  wire hit_flag = in_map && (reg_ofs == `PERM_CAPT_FLAG_OFS);
  wire hit_word3 = in_map && (reg_ofs == `PERM_HDR_WORD3_OFS);
  wire port_ok = ({30'h00000000, port_sel} < NUM_PORTS);
  wire data_phase = (bus_state == ST_DATA);
  wire do_write = data_phase && write_q && port_ok;

  // ==================================================================
  // Per-port state and register images
  reg [31:0] header_bytes_12_15 [0:NUM_PORTS-1];
  wire [31:0] rate_word [0:NUM_PORTS-1];
  wire [31:0] thresh_word [0:NUM_PORTS-1];

  genvar p;
  generate
    for (p = 0; p < NUM_PORTS; p = p + 1) begin : g_port
      wire sel_me = ({30'h00000000, port_sel} == p);
      wire wr_rate = do_write && sel_me && hit_rate;
      wire wr_thresh = do_write && sel_me && hit_thresh;
      wire clr_flag = do_write && sel_me && hit_flag &&
                      !hwdata[`PERM_CAPT_VALID_BIT];
      // A fresh capture is taken only while unlocked
      wire capture_take = capture_strobe[p] && !capture_valid_flag[p];

      perm_rate_counter u_counter (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .err_event(tx_error[p]),
        .ms_tick(ms_tick),
        .wr_rate(wr_rate),
        .wr_thresh(wr_thresh),
        .wdata(hwdata),
        .rate_word(rate_word[p]),
        .thresh_word(thresh_word[p]),
        .failed_report(failed_report[p]),
        .degraded_report(degraded_report[p])
      );

      // Capture word and its valid flag; a capture in the clearing
      // cycle cannot happen while locked, and after unlock the set wins.
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          header_bytes_12_15[p] <= 32'h00000000;
          capture_valid_flag[p] <= 1'b0;
        end else begin
          if (capture_take) begin
            header_bytes_12_15[p] <= capture_header_in[32*p +: 32];
            capture_valid_flag[p] <= 1'b1;
          end else if (clr_flag) begin
            capture_valid_flag[p] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ==================================================================
  // Read multiplexer; unmapped addresses read zero
  reg [31:0] next_rdata;
  always @* begin
    next_rdata = 32'h00000000;
    if (port_ok) begin
      if (hit_rate)
        next_rdata = rate_word[port_sel];
      else if (hit_thresh)
        next_rdata = thresh_word[port_sel];
      else if (hit_flag)
        next_rdata = {31'h00000000, capture_valid_flag[port_sel]};
      else if (hit_word3)
        next_rdata = header_bytes_12_15[port_sel];
    end
  end

  // ==================================================================
  // Bus state machine
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state <= ST_IDLE;
      addr_q <= 32'h00000000;
      write_q <= 1'b0;
      hreadyout <= 1'b1;
      hrdata <= 32'h00000000;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      case (bus_state)
        ST_IDLE: begin
          if (take) begin
            addr_q <= haddr;
            write_q <= hwrite;
            hreadyout <= 1'b0;
            bus_state <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (!write_q)
            hrdata <= next_rdata;
          hreadyout <= 1'b1;
          bus_state <= ST_IDLE;
        end
        default: begin
          bus_state <= ST_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end

endmodule // perm_top

`default_nettype wire

// ==== verification/perm_chk.sv ====
// Port-level assertions for the error-rate monitor
`timescale 1ns/1ps
`default_nettype none
module perm_chk #(
  parameter NUM_PORTS = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Bus
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Port events and state
  input wire logic [NUM_PORTS-1:0] tx_error,
  input wire logic [NUM_PORTS-1:0] capture_strobe,
  input wire logic [NUM_PORTS-1:0] failed_report,
  input wire logic [NUM_PORTS-1:0] degraded_report,
  input wire logic [NUM_PORTS-1:0] capture_valid_flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ========================================
  // Bus answer
  property p_one_wait; hsel && hready && htrans == 2'h2 |=> !hreadyout ##1 hreadyout; endproperty
  a_one_wait: assert property (p_one_wait) else $error("bus wait not one cycle");
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");
  // ========================================
  // Reports come only from counted errors unless a leak steps onto a nonzero threshold, one cycle each
  property p_fail_src; failed_report[1] |-> $past(tx_error[1]); endproperty
  a_fail_src: assert property (p_fail_src) else $error("failed report without error");
  property p_degr_src; degraded_report[1] |-> $past(tx_error[1]); endproperty
  a_degr_src: assert property (p_degr_src) else $error("degraded report without error");
  property p_fail_one; failed_report[1] |=> !failed_report[1]; endproperty
  a_fail_one: assert property (p_fail_one) else $error("failed report held");
  property p_degr_one; degraded_report[1] |=> !degraded_report[1]; endproperty
  a_degr_one: assert property (p_degr_one) else $error("degraded report held");
  // ========================================
  // Capture lock
  property p_capt_set; capture_strobe[2] && !capture_valid_flag[2] |=> capture_valid_flag[2]; endproperty
  a_capt_set: assert property (p_capt_set) else $error("capture flag not set");
  property p_capt_src; $rose(capture_valid_flag[2]) |-> $past(capture_strobe[2]); endproperty
  a_capt_src: assert property (p_capt_src) else $error("capture flag set by itself");
  property p_capt_lock; capture_valid_flag[2] && hreadyout |=> capture_valid_flag[2]; endproperty
  a_capt_lock: assert property (p_capt_lock) else $error("capture flag lost");
  property p_capt_clr; $fell(capture_valid_flag[2]) |-> !$past(hreadyout); endproperty
  a_capt_clr: assert property (p_capt_clr) else $error("capture flag cleared off a write");
endmodule // perm_chk
bind perm_top perm_chk #(.NUM_PORTS(NUM_PORTS)) perm_chk_i (.sys_clk(sys_clk), .rst_n(rst_n),
  .hsel(hsel), .htrans(htrans), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .tx_error(tx_error), .capture_strobe(capture_strobe), .failed_report(failed_report),
  .degraded_report(degraded_report), .capture_valid_flag(capture_valid_flag));
`default_nettype wire

// ==== verification/perm_link_partner.sv ====
// Behavioural error-detect side: error pulses and header captures per port
`timescale 1ns/1ps
`default_nettype none
module perm_link_partner (
  // Clock
  input wire logic sys_clk,
  // Toward the monitor
  output logic [3:0] tx_error,
  output logic [3:0] capture_strobe,
  output logic [127:0] capture_header_in
);
  initial begin
    tx_error = 4'h0;
    capture_strobe = 4'h0;
    capture_header_in = 128'h0;
  end
  // Gap 0 holds the line high, one error per cycle
  task automatic send_errors(input int p, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      tx_error[p] <= 1'b1;
      if (gap > 0) begin
        @(posedge sys_clk);
        tx_error[p] <= 1'b0;
        repeat (gap - 1) @(posedge sys_clk);
      end
    end
    @(posedge sys_clk);
    tx_error[p] <= 1'b0;
  endtask
  // Header is only valid with the strobe; inverted after so stale data never matches
  task automatic capture(input int p, input logic [31:0] h);
    @(posedge sys_clk);
    capture_strobe[p] <= 1'b1;
    capture_header_in[32*p +: 32] <= h;
    @(posedge sys_clk);
    capture_strobe[p] <= 1'b0;
    capture_header_in[32*p +: 32] <= ~h;
  endtask
endmodule // perm_link_partner
`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench for the four-port error-rate monitor
`timescale 1ns/1ps
`default_nettype none
`include "perm_regs.vh"
`define CHK(got, exp) begin \
  check_count++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("FAIL %0t got %h exp %h", $time, got, exp); \
  end \
end
module testbench;
  localparam logic [4:0] RATE = `PERM_RATE_OFS;
  localparam logic [4:0] THR = `PERM_THRESH_OFS;
  localparam logic [4:0] FLG = `PERM_CAPT_FLAG_OFS;
  localparam logic [4:0] HDR = `PERM_HDR_WORD3_OFS;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  wire hreadyout;
  wire hresp;
  wire [31:0] hrdata;
  wire [3:0] tx_error, capture_strobe, failed_report, degraded_report, capture_valid_flag;
  wire [127:0] capture_header_in;
  int n_mismatch = 0;
  int check_count = 0;
  int n_fail = 0;
  int n_degr = 0;
  always #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (failed_report[1] === 1'b1) n_fail++;
    if (degraded_report[1] === 1'b1) n_degr++;
  end
  // Short leak tick keeps millisecond periods within the run
  perm_top #(.NUM_PORTS(4), .LEAK_BASE_CYCLES(4)) perm_top_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .tx_error(tx_error), .capture_strobe(capture_strobe), .capture_header_in(capture_header_in),
    .failed_report(failed_report), .degraded_report(degraded_report),
    .capture_valid_flag(capture_valid_flag));
  perm_link_partner perm_link_partner_i (.sys_clk(sys_clk), .tx_error(tx_error),
    .capture_strobe(capture_strobe), .capture_header_in(capture_header_in));
  // ========================================
  // Bus master
  function automatic logic [31:0] ad(input int p, input logic [4:0] o);
    return 32'(p) * 32'h20 + {27'h0, o};
  endfunction
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
  endtask
  task automatic rchk(input int p, input logic [4:0] o, input logic [31:0] e);
    xfer(1'b0, ad(p, o), 32'h0);
    `CHK(rd, e)
  endtask
  // ========================================
  // Scenarios
  task automatic s_reset;
    rchk(0, RATE, 32'hff000000);
    rchk(0, THR, 32'hffff0000);
    rchk(0, HDR, 32'h0);
    xfer(1'b1, ad(4, RATE), 32'h0);
    rchk(4, RATE, 32'h0);
    rchk(0, RATE, 32'hff000000);
  endtask
  task automatic s_count;
    xfer(1'b1, ad(1, THR), 32'h04020000);
    xfer(1'b1, ad(1, RATE), 32'h0);
    perm_link_partner_i.send_errors(1, 8, 0);
    rchk(1, RATE, 32'h00000606);
    `CHK(n_fail, 1)
    `CHK(n_degr, 1)
  endtask
  task automatic s_caps;
    logic [7:0] grow [4] = '{8'h02, 8'h04, 8'h10, 8'h00};
    logic [7:0] pk;
    int d0;
    int f0;
    for (int c = 0; c < 4; c++) begin
      d0 = n_degr;
      f0 = n_fail;
      xfer(1'b1, ad(1, THR), 32'h04030000);
      xfer(1'b1, ad(1, RATE), 32'(c) << 16);
      perm_link_partner_i.send_errors(1, 30, 1);
      pk = (c == 3) ? 8'h1e : 8'h04 + grow[c];
      rchk(1, RATE, {14'h0, 2'(c), pk, pk});
      `CHK(n_degr, d0 + 1)
      `CHK(n_fail, f0 + 1)
    end
  endtask
  task automatic s_fail0;
    int f0;
    f0 = n_fail;
    xfer(1'b1, ad(1, THR), 32'h00030000);
    xfer(1'b1, ad(1, RATE), 32'h0);
    perm_link_partner_i.send_errors(1, 10, 0);
    rchk(1, RATE, 32'h00000a0a);
    `CHK(n_fail, f0)
    xfer(1'b1, ad(1, THR), 32'h0);
    xfer(1'b1, ad(1, RATE), 32'h000300fe);
    perm_link_partner_i.send_errors(1, 3, 0);
    rchk(1, RATE, 32'h0003ffff);
  endtask
  // Both thresholds zero: a leak down to zero must not report
  task automatic s_leak;
    int d0;
    int f0;
    d0 = n_degr;
    f0 = n_fail;
    xfer(1'b1, ad(1, THR), 32'h0);
    xfer(1'b1, ad(1, RATE), 32'h01000303);
    repeat (100) @(posedge sys_clk);
    rchk(1, RATE, 32'h01000300);
    `CHK(n_fail, f0)
    `CHK(n_degr, d0)
    xfer(1'b1, ad(1, RATE), 32'h03000505);
    repeat (60) @(posedge sys_clk);
    rchk(1, RATE, 32'h03000504);
    xfer(1'b1, ad(1, RATE), 32'h00000505);
    repeat (100) @(posedge sys_clk);
    rchk(1, RATE, 32'h00000505);
  endtask
  task automatic s_capture;
    perm_link_partner_i.capture(2, 32'h11223344);
    rchk(2, FLG, 32'h1);
    rchk(2, HDR, 32'h11223344);
    perm_link_partner_i.capture(2, 32'h55667788);
    xfer(1'b1, ad(2, HDR), 32'h0);
    rchk(2, HDR, 32'h11223344);
    rchk(3, HDR, 32'h0);
    xfer(1'b1, ad(2, FLG), 32'h1);
    rchk(2, FLG, 32'h1);
    xfer(1'b1, ad(2, FLG), 32'h0);
    rchk(2, FLG, 32'h0);
    perm_link_partner_i.capture(2, 32'h55667788);
    rchk(2, HDR, 32'h55667788);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    complete_run;
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_n <= 1'b1;
    s_reset;
    s_count;
    s_caps;
    s_fail0;
    s_leak;
    s_capture;
    complete_run;
  end
endmodule // testbench
`default_nettype wire
